// *** core/fspc_regs.vh ***
`ifndef FSPC_REGS_VH
`define FSPC_REGS_VH

// register byte offsets
`define FSPC_OFS_ADDR_LOW 3'h0
`define FSPC_OFS_ADDR_HIGH 3'h1
`define FSPC_OFS_DATA_LOW 3'h2
`define FSPC_OFS_DATA_HIGH 3'h3
`define FSPC_OFS_CTRL 3'h4
`define FSPC_OFS_KEY 3'h5

// flash_ctrl_reg bit positions
`define FSPC_BIT_RD 0
`define FSPC_BIT_WR 1
`define FSPC_BIT_WRITE_ENABLE_BIT 2
`define FSPC_BIT_WRITE_ERROR_FLAG 3
`define FSPC_BIT_LOAD_LATCHES_ONLY_BIT 4
`define FSPC_BIT_FREE 5
`define FSPC_BIT_CONFIG_SPACE_SELECT 6

// reset values
`define FSPC_RST_BYTE 8'h00
`define FSPC_RST_ADDR 15'h0000
`define FSPC_RST_DATA 14'h0000
`define FSPC_BLANK_WORD 14'h3FFF

// unlock keys
`define FSPC_KEY_FIRST 8'h55
`define FSPC_KEY_SECOND 8'hAA

// write protect upper limits (exclusive word address)
`define FSPC_WRT_LIMIT_ALL 15'h7FFF
`define FSPC_WRT_LIMIT_HALF 15'h0400
`define FSPC_WRT_LIMIT_LOW 15'h0200

// timing
`define FSPC_CLK_MHZ 250
`define FSPC_OP_TIME_US 2000
`define FSPC_CLK_PER_ICYC 2'h3
`define FSPC_FORCED_NOPS 2'h2

`endif

// *** core/fspc_latch_mem.v ***
`timescale 1ns/100ps
`include "fspc_regs.vh"

module fspc_latch_mem (
  input wire ref_clk,
  input wire rst,
  input wire clr,
  input wire we,
  input wire [3:0] waddr,
  input wire [13:0] wdata,
  input wire [3:0] raddr,
  output reg [13:0] rdata
);
  reg [13:0] mem [0:15];
  genvar i;

  // each latch returns to blank on reset or clear
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_latch
      always @(posedge ref_clk) begin
        if (rst || clr) begin
          mem[i] <= `FSPC_BLANK_WORD;
        end else if (we && waddr == i[3:0]) begin
          mem[i] <= wdata;
        end
      end
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (rst) begin
      rdata <= `FSPC_BLANK_WORD;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // fspc_latch_mem

// *** core/fspc_op_timer.v ***
`timescale 1ns/100ps

module fspc_op_timer #(
  parameter [19:0] OP_CYCLES = 20'd500000
) (
  input wire ref_clk,
  input wire rst,
  input wire abort,
  input wire start,
  output reg done
);
  reg [19:0] count;
  reg running;

  always @(posedge ref_clk) begin
    if (rst || abort) begin
      count <= 20'h00000;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= OP_CYCLES - 20'h00001;
        running <= 1'b1;
      end else if (running) begin
        if (count == 20'h00000) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 20'h00001;
        end
      end
    end
  end
endmodule // fspc_op_timer

// *** core/fspc_ctrl.v ***
// Functional notes
// - data pair holds a 14-bit word split over two bytes
// - address pair holds a 15-bit word address, high and low bytes
// - address pair reaches any of 32K program words
// - erase and program time comes from an internal timer
// - code protect at 0 blocks external programmer access, not self-write
// - write protect field blocks self-write and erase in its region
// - read and write start bits are set-only, cleared by hardware when done
// - writes need write enable; write enable clears at power-up
// - reset during a write sets the write error flag
// - unlock key register is write-only and reads as zero
// - erase works on 16-word rows; sixteen write latches
// - latches are not readable, loaded only via the data pair
// - blank words may be programmed without a prior erase
// - second instruction after read start is used for the flash access
// - data pair keeps the word until next read or software write
// - latch load, erase, program need an unbroken unlock sequence
// - setting write start forces the next two instructions to no-ops
// - row erase or program stalls the core about 2 ms
// - latch load does not stall after the forced no-ops
// - load-latches-only set fills one latch; clear programs the row
// - upper 11 address bits pick the row, low 4 the latch
// - latches return to 3FFF after every row program or erase
// - erase select with write enable erases the addressed row
`timescale 1ns/100ps
`include "fspc_regs.vh"

module fspc_ctrl #(
  parameter [19:0] OP_CYCLES = `FSPC_OP_TIME_US * `FSPC_CLK_MHZ
) (
  input wire ref_clk,
  input wire rst,
  input wire sys_reset,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire code_protect_bit,
  input wire [1:0] write_protect_field,
  input wire [13:0] flash_rdata,
  output reg [14:0] flash_addr,
  output reg [13:0] flash_wdata,
  output reg flash_cfg_space,
  output reg flash_read,
  output reg flash_prog,
  output reg flash_erase,
  output reg ext_access_block,
  output reg cpu_force_nop,
  output reg cpu_stall
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD_WAIT = 3'h1;
  localparam [2:0] ST_RD_LOAD = 3'h2;
  localparam [2:0] ST_NOPS = 3'h3;
  localparam [2:0] ST_PROG = 3'h4;
  localparam [2:0] ST_OP_WAIT = 3'h5;

  localparam [1:0] UL_IDLE = 2'h0;
  localparam [1:0] UL_KEY1 = 2'h1;
  localparam [1:0] UL_KEY2 = 2'h2;

  reg [14:0] flash_addr_reg;
  reg [13:0] flash_data_reg;
  reg rd_bit;
  reg wr_bit;
  reg write_enable_bit;
  reg write_error_flag;
  reg load_latches_only_bit;
  reg erase_select_bit;
  reg config_space_select;
  reg [2:0] state;
  reg [1:0] ul_state;
  reg [1:0] icyc_div;
  reg [1:0] nop_left;
  reg rd_slot;
  reg op_pending;
  reg op_is_erase;
  reg [3:0] prog_idx;
  reg prog_issue;
  reg [3:0] prog_idx_d;
  reg prog_last;
  reg timer_start;
  reg latch_clr;
  reg latch_we;
  wire [13:0] latch_rdata;
  wire timer_done;
  wire icyc_en;
  wire ctrl_wr;
  wire wr_set;
  wire rd_set;
  wire unlocked;
  wire wp_hit;
  reg [14:0] wp_limit;

  // one instruction cycle every four core clocks
  assign icyc_en = (icyc_div == `FSPC_CLK_PER_ICYC);
  assign ctrl_wr = reg_wr && reg_addr == `FSPC_OFS_CTRL;
  assign wr_set = ctrl_wr && reg_wdata[`FSPC_BIT_WR] && !wr_bit && state == ST_IDLE;
  assign rd_set = ctrl_wr && reg_wdata[`FSPC_BIT_RD] && !rd_bit && !wr_set &&
                  state == ST_IDLE;
  assign unlocked = ul_state == UL_KEY2;

  always @* begin
    if (write_protect_field == 2'h0) begin
      wp_limit = `FSPC_WRT_LIMIT_ALL;
    end else if (write_protect_field == 2'h1) begin
      wp_limit = `FSPC_WRT_LIMIT_HALF;
    end else if (write_protect_field == 2'h2) begin
      wp_limit = `FSPC_WRT_LIMIT_LOW;
    end else begin
      wp_limit = 15'h0000;
    end
  end

  // row start decides protection since one operation never leaves its row
  assign wp_hit = {flash_addr_reg[14:4], 4'h0} < wp_limit;

  fspc_latch_mem u_latches (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(latch_clr),
    .we(latch_we),
    .waddr(flash_addr_reg[3:0]),
    .wdata(flash_data_reg),
    .raddr(prog_idx),
    .rdata(latch_rdata)
  );

  fspc_op_timer #(
    .OP_CYCLES(OP_CYCLES)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .abort(sys_reset),
    .start(timer_start),
    .done(timer_done)
  );

  always @(posedge ref_clk) begin
    if (rst) begin
      icyc_div <= 2'h0;
    end else begin
      icyc_div <= icyc_div + 2'h1;
    end
  end

  // unlock detector: any access that is not the next step drops it
  always @(posedge ref_clk) begin
    if (rst || sys_reset) begin
      ul_state <= UL_IDLE;
    end else if (reg_wr || reg_rd) begin
      if (reg_wr && reg_addr == `FSPC_OFS_KEY && reg_wdata == `FSPC_KEY_FIRST) begin
        ul_state <= UL_KEY1;
      end else if (ul_state == UL_KEY1 && reg_wr && reg_addr == `FSPC_OFS_KEY &&
                   reg_wdata == `FSPC_KEY_SECOND) begin
        ul_state <= UL_KEY2;
      end else begin
        ul_state <= UL_IDLE;
      end
    end
  end

  // error flag survives the system reset; power-up clears it, a control register write loads it from bit 3
  always @(posedge ref_clk) begin
    if (rst) begin
      write_error_flag <= 1'b0;
    end else if (sys_reset && wr_bit) begin
      write_error_flag <= 1'b1;
    end else if (ctrl_wr) begin
      write_error_flag <= reg_wdata[`FSPC_BIT_WRITE_ERROR_FLAG];
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ext_access_block <= 1'b0;
    end else begin
      ext_access_block <= !code_protect_bit;
    end
  end

  always @(posedge ref_clk) begin
    if (rst || sys_reset) begin
      flash_addr_reg <= `FSPC_RST_ADDR;
      flash_data_reg <= `FSPC_RST_DATA;
      rd_bit <= 1'b0;
      wr_bit <= 1'b0;
      write_enable_bit <= 1'b0;
      load_latches_only_bit <= 1'b0;
      erase_select_bit <= 1'b0;
      config_space_select <= 1'b0;
      state <= ST_IDLE;
      nop_left <= 2'h0;
      rd_slot <= 1'b0;
      op_pending <= 1'b0;
      op_is_erase <= 1'b0;
      prog_idx <= 4'h0;
      prog_issue <= 1'b0;
      prog_idx_d <= 4'h0;
      prog_last <= 1'b0;
      timer_start <= 1'b0;
      latch_clr <= 1'b0;
      latch_we <= 1'b0;
      flash_addr <= `FSPC_RST_ADDR;
      flash_wdata <= `FSPC_BLANK_WORD;
      flash_cfg_space <= 1'b0;
      flash_read <= 1'b0;
      flash_prog <= 1'b0;
      flash_erase <= 1'b0;
      cpu_force_nop <= 1'b0;
      cpu_stall <= 1'b0;
    end else begin
      flash_read <= 1'b0;
      flash_prog <= 1'b0;
      flash_erase <= 1'b0;
      timer_start <= 1'b0;
      latch_clr <= 1'b0;
      latch_we <= 1'b0;
      if (reg_wr) begin
        if (reg_addr == `FSPC_OFS_ADDR_LOW) begin
          flash_addr_reg[7:0] <= reg_wdata;
        end else if (reg_addr == `FSPC_OFS_ADDR_HIGH) begin
          flash_addr_reg[14:8] <= reg_wdata[6:0];
        end else if (reg_addr == `FSPC_OFS_DATA_LOW) begin
          flash_data_reg[7:0] <= reg_wdata;
        end else if (reg_addr == `FSPC_OFS_DATA_HIGH) begin
          flash_data_reg[13:8] <= reg_wdata[5:0];
        end else if (reg_addr == `FSPC_OFS_CTRL) begin
          write_enable_bit <= reg_wdata[`FSPC_BIT_WRITE_ENABLE_BIT];
          load_latches_only_bit <= reg_wdata[`FSPC_BIT_LOAD_LATCHES_ONLY_BIT];
          erase_select_bit <= reg_wdata[`FSPC_BIT_FREE];
          config_space_select <= reg_wdata[`FSPC_BIT_CONFIG_SPACE_SELECT];
        end
      end
      if (icyc_en && nop_left != 2'h0) begin
        nop_left <= nop_left - 2'h1;
      end
      cpu_force_nop <= (nop_left != 2'h0) || rd_slot;
      case (state)
        ST_IDLE: begin
          if (rd_set) begin
            rd_bit <= 1'b1;
            state <= ST_RD_WAIT;
          end else if (wr_set) begin
            wr_bit <= 1'b1;
            nop_left <= `FSPC_FORCED_NOPS;
            cpu_force_nop <= 1'b1;
            state <= ST_NOPS;
            op_pending <= 1'b0;
            // locked, disabled or protected starts are dropped silently
            if (unlocked && write_enable_bit && !config_space_select) begin
              if (erase_select_bit) begin
                op_pending <= !wp_hit;
                op_is_erase <= 1'b1;
              end else if (load_latches_only_bit) begin
                latch_we <= 1'b1;
              end else begin
                op_pending <= !wp_hit;
                op_is_erase <= 1'b0;
              end
            end
          end
        end
        ST_RD_WAIT: begin
          // first instruction after the start runs, the second is the access slot
          if (icyc_en) begin
            if (rd_slot) begin
              rd_slot <= 1'b0;
              flash_read <= 1'b1;
              flash_addr <= flash_addr_reg;
              flash_cfg_space <= config_space_select;
              state <= ST_RD_LOAD;
            end else begin
              rd_slot <= 1'b1;
            end
          end
        end
        ST_RD_LOAD: begin
          if (!flash_read) begin
            flash_data_reg <= flash_rdata;
            rd_bit <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_NOPS: begin
          if (nop_left == 2'h0) begin
            if (op_pending && op_is_erase) begin
              flash_erase <= 1'b1;
              flash_addr <= {flash_addr_reg[14:4], 4'h0};
              flash_cfg_space <= 1'b0;
              timer_start <= 1'b1;
              cpu_stall <= 1'b1;
              state <= ST_OP_WAIT;
            end else if (op_pending) begin
              prog_idx <= 4'h0;
              prog_issue <= 1'b0;
              prog_last <= 1'b0;
              cpu_stall <= 1'b1;
              state <= ST_PROG;
            end else begin
              wr_bit <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        ST_PROG: begin
          // latch read is registered, so the issue lags the index by one
          prog_issue <= !prog_last;
          prog_idx_d <= prog_idx;
          if (prog_idx == 4'hF) begin
            prog_last <= 1'b1;
          end else begin
            prog_idx <= prog_idx + 4'h1;
          end
          if (prog_issue && latch_rdata != `FSPC_BLANK_WORD) begin
            flash_prog <= 1'b1;
            flash_addr <= {flash_addr_reg[14:4], prog_idx_d};
            flash_wdata <= latch_rdata;
            flash_cfg_space <= 1'b0;
          end
          if (prog_issue && prog_idx_d == 4'hF) begin
            timer_start <= 1'b1;
            prog_issue <= 1'b0;
            state <= ST_OP_WAIT;
          end
        end
        ST_OP_WAIT: begin
          if (timer_done) begin
            latch_clr <= 1'b1;
            wr_bit <= 1'b0;
            cpu_stall <= 1'b0;
            op_pending <= 1'b0;
            prog_idx <= 4'h0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped and key read zero
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= `FSPC_RST_BYTE;
    end else if (reg_rd) begin
      if (reg_addr == `FSPC_OFS_ADDR_LOW) begin
        reg_rdata <= flash_addr_reg[7:0];
      end else if (reg_addr == `FSPC_OFS_ADDR_HIGH) begin
        reg_rdata <= {1'b0, flash_addr_reg[14:8]};
      end else if (reg_addr == `FSPC_OFS_DATA_LOW) begin
        reg_rdata <= flash_data_reg[7:0];
      end else if (reg_addr == `FSPC_OFS_DATA_HIGH) begin
        reg_rdata <= {2'h0, flash_data_reg[13:8]};
      end else if (reg_addr == `FSPC_OFS_CTRL) begin
        reg_rdata <= {1'b0, config_space_select, erase_select_bit,
                      load_latches_only_bit, write_error_flag,
                      write_enable_bit, wr_bit, rd_bit};
      end else begin
        reg_rdata <= `FSPC_RST_BYTE;
      end
    end else begin
      reg_rdata <= `FSPC_RST_BYTE;
    end
  end
endmodule // fspc_ctrl

// *** sim/fspc_props.sv ***
`timescale 1ns/100ps
`include "fspc_regs.vh"
module fspc_props #(
  parameter [19:0] OP_CYCLES = 20'd500000
) (
  input wire ref_clk,
  input wire rst,
  input wire sys_reset,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire code_protect_bit,
  input wire [1:0] write_protect_field,
  input wire [14:0] flash_addr,
  input wire [13:0] flash_wdata,
  input wire flash_read,
  input wire flash_prog,
  input wire flash_erase,
  input wire ext_access_block,
  input wire cpu_force_nop,
  input wire cpu_stall
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || sys_reset);
  reg [19:0] scnt;
  wire ctl_wr = reg_wr && reg_addr == `FSPC_OFS_CTRL && !cpu_force_nop && !cpu_stall;
  always @(posedge ref_clk) begin
    if (rst || !cpu_stall) scnt <= 20'h00000;
    else scnt <= scnt + 20'h00001;
  end
  property p_key_rd; reg_rd && reg_addr >= `FSPC_OFS_KEY |=> reg_rdata == 8'h00; endproperty
  a_key_rd: assert property (p_key_rd) else $error("key read not zero");
  property p_ext; 1'b1 |=> ext_access_block == !$past(code_protect_bit); endproperty
  a_ext: assert property (p_ext) else $error("external block wrong");
  property p_rd; ctl_wr && reg_wdata[0] && !reg_wdata[1] |-> ##[2:12] flash_read; endproperty
  a_rd: assert property (p_rd) else $error("no array read");
  property p_wr; ctl_wr && reg_wdata[1] && !reg_wdata[0] |=> cpu_force_nop; endproperty
  a_wr: assert property (p_wr) else $error("no forced nop");
  property p_nop; $rose(cpu_force_nop) |-> cpu_force_nop [*4]; endproperty
  a_nop: assert property (p_nop) else $error("forced nop too short");
  property p_erase; flash_erase |-> (flash_addr[3:0] == 4'h0) ##[0:2] cpu_stall; endproperty
  a_erase: assert property (p_erase) else $error("erase not row aligned");
  property p_prog; flash_prog |-> flash_wdata != `FSPC_BLANK_WORD && cpu_stall; endproperty
  a_prog: assert property (p_prog) else $error("bad program pulse");
  property p_wp;
    flash_prog || flash_erase |-> write_protect_field == 2'b11
      || (write_protect_field == 2'b01 && flash_addr >= `FSPC_WRT_LIMIT_HALF)
      || (write_protect_field == 2'b10 && flash_addr >= `FSPC_WRT_LIMIT_LOW);
  endproperty
  a_wp: assert property (p_wp) else $error("protected region written");
  property p_slen; $fell(cpu_stall) && !$past(sys_reset) |-> scnt >= OP_CYCLES; endproperty
  a_slen: assert property (p_slen) else $error("stall shorter than timer");
  c_read: cover property (flash_read);
  c_erase: cover property (flash_erase);
  c_prog: cover property (flash_prog);
endmodule // fspc_props
bind fspc_ctrl fspc_props #(.OP_CYCLES(OP_CYCLES)) props_u (
  .ref_clk(ref_clk),
  .rst(rst),
  .sys_reset(sys_reset),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .code_protect_bit(code_protect_bit),
  .write_protect_field(write_protect_field),
  .flash_addr(flash_addr),
  .flash_wdata(flash_wdata),
  .flash_read(flash_read),
  .flash_prog(flash_prog),
  .flash_erase(flash_erase),
  .ext_access_block(ext_access_block),
  .cpu_force_nop(cpu_force_nop),
  .cpu_stall(cpu_stall)
);

// *** sim/fspc_flash_model.sv ***
`timescale 1ns/100ps
module fspc_flash_model (
  input wire ref_clk,
  input wire flash_read,
  input wire flash_cfg_space,
  input wire flash_prog,
  input wire flash_erase,
  input wire [14:0] flash_addr,
  input wire [13:0] flash_wdata,
  output reg [13:0] flash_rdata
);
  reg [13:0] mem [0:32767];
  integer i;
  initial begin
    flash_rdata = 14'h0000;
    for (i = 0; i < 32768; i = i + 1) begin
      mem[i] = (i < 4096) ? 14'h3FFF : (i[13:0] ^ 14'h1555);
    end
  end
  always @(posedge ref_clk) begin
    if (flash_read) begin
      flash_rdata <= flash_cfg_space ? ~flash_addr[13:0] : mem[flash_addr];
    end else begin
      // no stale word in the cycle right after the answer cycle
      flash_rdata <= ~flash_rdata;
    end
    if (flash_prog) begin
      mem[flash_addr] <= mem[flash_addr] & flash_wdata;
    end
    if (flash_erase) begin
      for (i = 0; i < 16; i = i + 1) begin
        mem[{flash_addr[14:4], i[3:0]}] <= 14'h3FFF;
      end
    end
  end
endmodule // fspc_flash_model

// *** sim/testbench.sv ***
`timescale 1ns/100ps
`include "fspc_regs.vh"
module testbench;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg sys_reset = 1'b0;
  reg [2:0] reg_addr = 3'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg code_protect_bit = 1'b1;
  reg [1:0] write_protect_field = 2'b11;
  wire [7:0] reg_rdata;
  wire [13:0] flash_rdata, flash_wdata;
  wire [14:0] flash_addr;
  wire flash_cfg_space, flash_read, flash_prog, flash_erase;
  wire ext_access_block, cpu_force_nop, cpu_stall;
  integer failures = 0;
  integer tests_run = 0;
  integer cycles = 0;
  integer prog_cnt = 0;
  integer erase_cnt = 0;
  reg [14:0] mon_addr = 15'h0000;
  reg [13:0] mon_data = 14'h0000;
  reg nop_seen = 1'b0;
  reg stall_seen = 1'b0;
  reg [7:0] rd;
  always #2 ref_clk = ~ref_clk;
  fspc_ctrl #(.OP_CYCLES(20'd20)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .sys_reset(sys_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .code_protect_bit(code_protect_bit), .write_protect_field(write_protect_field),
    .flash_rdata(flash_rdata), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_cfg_space(flash_cfg_space), .flash_read(flash_read), .flash_prog(flash_prog),
    .flash_erase(flash_erase), .ext_access_block(ext_access_block),
    .cpu_force_nop(cpu_force_nop), .cpu_stall(cpu_stall));
  fspc_flash_model flash_u (
    .ref_clk(ref_clk), .flash_read(flash_read), .flash_cfg_space(flash_cfg_space),
    .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_rdata(flash_rdata));
  task results;
    begin
      $display("tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (flash_prog) begin
      prog_cnt = prog_cnt + 1;
      mon_data <= flash_wdata;
    end
    if (flash_erase) erase_cnt = erase_cnt + 1;
    if (flash_read || flash_prog || flash_erase) mon_addr <= flash_addr;
    if (cpu_force_nop) nop_seen <= 1'b1;
    if (cpu_stall) stall_seen <= 1'b1;
    if (cycles == 20000) begin
      failures = failures + 1;
      results;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rdr(input [2:0] a);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
    end
  endtask
  task unlock(input [7:0] c);
    begin
      // mode bits land before the keys; the start write sees them already registered
      wr(`FSPC_OFS_CTRL, c);
      wr(`FSPC_OFS_KEY, `FSPC_KEY_FIRST);
      wr(`FSPC_OFS_KEY, `FSPC_KEY_SECOND);
      wr(`FSPC_OFS_CTRL, c | 8'h02);
    end
  endtask
  task wait_idle;
    integer n;
    begin
      n = 0;
      rd = 8'hFF;
      while ((rd & 8'h03) !== 8'h00 && n < 300) begin
        rdr(`FSPC_OFS_CTRL);
        n = n + 1;
      end
      chk(rd & 8'h03, 16'h0000);
    end
  endtask
  task set_ad(input [14:0] a, input [13:0] d);
    begin
      wr(`FSPC_OFS_ADDR_HIGH, {1'b0, a[14:8]});
      wr(`FSPC_OFS_ADDR_LOW, a[7:0]);
      wr(`FSPC_OFS_DATA_HIGH, {2'b00, d[13:8]});
      wr(`FSPC_OFS_DATA_LOW, d[7:0]);
    end
  endtask
  task read_word(input [14:0] a, input [13:0] exp);
    begin
      set_ad(a, 14'h0000);
      wr(`FSPC_OFS_CTRL, 8'h01);
      // a software clear must not cut the read short
      wr(`FSPC_OFS_CTRL, 8'h00);
      rdr(`FSPC_OFS_CTRL);
      chk(rd[0], 16'h0001);
      wait_idle;
      chk(mon_addr, a);
      rdr(`FSPC_OFS_DATA_LOW);
      chk(rd, exp[7:0]);
      rdr(`FSPC_OFS_DATA_HIGH);
      chk(rd, {2'b00, exp[13:8]});
    end
  endtask
  task t_regs;
    begin
      rdr(`FSPC_OFS_CTRL);
      chk(rd, 16'h0000);
      wr(`FSPC_OFS_KEY, 8'h55);
      rdr(`FSPC_OFS_KEY);
      chk(rd, 16'h0000);
      rdr(3'h7);
      chk(rd, 16'h0000);
      wr(`FSPC_OFS_ADDR_HIGH, 8'hFF);
      rdr(`FSPC_OFS_ADDR_HIGH);
      chk(rd, 16'h007F);
      wr(`FSPC_OFS_DATA_HIGH, 8'hFF);
      rdr(`FSPC_OFS_DATA_HIGH);
      chk(rd, 16'h003F);
    end
  endtask
  task t_read;
    begin
      read_word(15'h1234, 14'h1234 ^ 14'h1555);
      rdr(`FSPC_OFS_CTRL);
      rdr(`FSPC_OFS_DATA_LOW);
      chk(rd, 16'h0061);
      // config space read: the model answers with the inverted address
      wr(`FSPC_OFS_CTRL, 8'h41);
      wait_idle;
      rdr(`FSPC_OFS_DATA_LOW);
      chk(rd, 16'h00CB);
      rdr(`FSPC_OFS_DATA_HIGH);
      chk(rd, 16'h002D);
    end
  endtask
  task t_latch;
    begin
      set_ad(15'h0803, 14'h0123);
      nop_seen <= 1'b0;
      stall_seen <= 1'b0;
      unlock(8'h14);
      wait_idle;
      chk(nop_seen, 16'h0001);
      chk(stall_seen, 16'h0000);
      set_ad(15'h0805, 14'h0456);
      wr(`FSPC_OFS_KEY, `FSPC_KEY_FIRST);
      rdr(`FSPC_OFS_CTRL);
      wr(`FSPC_OFS_KEY, `FSPC_KEY_SECOND);
      wr(`FSPC_OFS_CTRL, 8'h16);
      wait_idle;
      set_ad(15'h0806, 14'h0789);
      unlock(8'h10);
      wait_idle;
      set_ad(15'h0807, 14'h3FFF);
      prog_cnt = 0;
      stall_seen <= 1'b0;
      unlock(8'h04);
      wait_idle;
      chk(prog_cnt[15:0], 16'h0001);
      chk(mon_addr, 16'h0803);
      chk(mon_data, 16'h0123);
      chk(stall_seen, 16'h0001);
      read_word(15'h0803, 14'h0123);
      prog_cnt = 0;
      unlock(8'h04);
      wait_idle;
      chk(prog_cnt[15:0], 16'h0000);
    end
  endtask
  task t_erase;
    begin
      code_protect_bit <= 1'b0;
      set_ad(15'h0805, 14'h0000);
      erase_cnt = 0;
      unlock(8'h24);
      wait_idle;
      chk(erase_cnt[15:0], 16'h0001);
      chk(mon_addr, 16'h0800);
      chk(ext_access_block, 16'h0001);
      read_word(15'h0803, 14'h3FFF);
      code_protect_bit <= 1'b1;
    end
  endtask
  task t_wp;
    begin
      write_protect_field <= 2'b01;
      set_ad(15'h0100, 14'h0000);
      erase_cnt = 0;
      stall_seen <= 1'b0;
      unlock(8'h24);
      wait_idle;
      chk(erase_cnt[15:0], 16'h0000);
      chk(stall_seen, 16'h0000);
      set_ad(15'h1235, 14'h0000);
      unlock(8'h24);
      wait_idle;
      chk(erase_cnt[15:0], 16'h0001);
      read_word(15'h1234, 14'h3FFF);
      write_protect_field <= 2'b11;
      chk(ext_access_block, 16'h0000);
    end
  endtask
  task t_write_error_flag;
    integer n;
    begin
      set_ad(15'h1240, 14'h0000);
      unlock(8'h24);
      n = 0;
      while (cpu_stall !== 1'b1 && n < 40) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      sys_reset <= 1'b1;
      @(posedge ref_clk);
      sys_reset <= 1'b0;
      rdr(`FSPC_OFS_CTRL);
      chk(rd[3], 16'h0001);
      chk(cpu_stall, 16'h0000);
      wr(`FSPC_OFS_CTRL, 8'h00);
      rdr(`FSPC_OFS_CTRL);
      chk(rd[3], 16'h0000);
    end
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_read;
    t_latch;
    t_erase;
    t_wp;
    t_write_error_flag;
    results;
  end
endmodule // testbench
